// ### core/cwb_defs.vh
// Constants for the collapsing write buffer bus unit.
// Assumes byte-addressed 32-bit words and 16-byte blocks.
`ifndef CWB_DEFS_VH
`define CWB_DEFS_VH

// ==========================================================
// Geometry
`define CWB_BLK_BYTES      16
`define CWB_WORD_LANES     4
`define CWB_BLK_LSB        4
`define CWB_WIDX_MSB       3
`define CWB_WIDX_LSB       2
`define CWB_FIFO_DEPTH     32
`define CWB_FIFO_AW        5

// ==========================================================
// Byte lane enable patterns
`define CWB_BE_NONE        4'h0
`define CWB_BE_B0          4'h1
`define CWB_BE_B1          4'h2
`define CWB_BE_B2          4'h4
`define CWB_BE_B3          4'h8
`define CWB_BE_LO_HALF     4'h3
`define CWB_BE_HI_HALF     4'hC
`define CWB_BE_WORD        4'hF
`define CWB_BLK_FULL       16'hFFFF
`define CWB_BLK_EMPTY      16'h0000

// ==========================================================
// FIFO entry layout {write, last, word address, enables, data}
`define CWB_ENTRY_W        68
`define CWB_ENT_WR         67
`define CWB_ENT_LAST       66
`define CWB_ENT_ADDR_MSB   65
`define CWB_ENT_ADDR_LSB   36
`define CWB_ENT_BE_MSB     35
`define CWB_ENT_BE_LSB     32
`define CWB_ENT_DATA_MSB   31
`define CWB_ENT_DATA_LSB   0

`endif

// ### core/cwb_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; storage is flip-flops indexed by pointers.
module cwb_fifo #(
  parameter WIDTH = 68,
  parameter DEPTH = 32,
  parameter AW    = 5
)(
  input  wire             clock,
  input  wire             arst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  // ==========================================================
  // Flags
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ==========================================================
  // Pointers and storage
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end

  // Data array has no reset; out_data is only valid while count_ff is nonzero
  always @(posedge clock)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

endmodule

// ### core/cwb_biu.v
// Write path of the external bus unit: collapsing write buffer in two halves.
// Assumes core requests and bus agent share this clock; mode straps are static.
`include "cwb_defs.vh"

module cwb_biu (
  input  wire        clock,
  input  wire        arst_n,
  input  wire        merge_full_mode,
  input  wire        aligned_enable_mode,
  input  wire        core_req_valid,
  output wire        core_req_ready,
  input  wire        core_req_write,
  input  wire        core_req_uncached,
  input  wire        core_req_barrier,
  input  wire [31:0] core_req_addr,
  input  wire [3:0]  core_req_be,
  input  wire [31:0] core_req_wdata,
  output wire        core_rvalid,
  output wire [31:0] core_rdata,
  output wire        bus_valid,
  input  wire        bus_ready,
  output wire        bus_write,
  output wire        bus_last,
  output wire [31:0] bus_addr,
  output wire [3:0]  bus_byte_lane_enables,
  output wire [31:0] bus_wdata,
  input  wire        bus_rvalid,
  input  wire [31:0] bus_rdata
);

  // ==========================================================
  // Helpers
  function is_simple;
    input [3:0] be;
    begin
      is_simple = (be == `CWB_BE_B0) || (be == `CWB_BE_B1) || (be == `CWB_BE_B2) ||
                  (be == `CWB_BE_B3) || (be == `CWB_BE_LO_HALF) ||
                  (be == `CWB_BE_HI_HALF) || (be == `CWB_BE_WORD);
    end
  endfunction

  // Next piece to issue from a word's remaining lanes
  function [3:0] first_part;
    input [3:0] be;
    input       aligned;
    begin
      if (!aligned || is_simple(be))
        first_part = be;
      else if ((be & `CWB_BE_LO_HALF) == `CWB_BE_LO_HALF)
        first_part = `CWB_BE_LO_HALF;
      else if ((be & `CWB_BE_HI_HALF) == `CWB_BE_HI_HALF)
        first_part = `CWB_BE_HI_HALF;
      else
        first_part = be & (~be + 4'h1);
    end
  endfunction

  function [3:0] word_be;
    input [15:0] be16;
    input [1:0]  idx;
    begin
      word_be = be16[idx*`CWB_WORD_LANES +: `CWB_WORD_LANES];
    end
  endfunction
  // ==========================================================
  // Declarations
  reg  [1:0]   mode_s1_ff, mode_s2_ff;
  reg          ready_ff, pend_valid_ff, pend_write_ff, pend_unc_ff, pend_barrier_ff;
  reg  [31:0]  pend_addr_ff, pend_data_ff;
  reg  [3:0]   pend_be_ff;
  reg          acc_valid_ff, xfr_read_ff;
  reg  [27:0]  acc_blk_ff, xfr_blk_ff;
  reg  [127:0] acc_data_ff, xfr_data_ff;
  reg  [15:0]  acc_be_ff, xfr_be_ff;
  reg  [1:0]   xfr_ridx_ff;
  reg  [3:0]   xfr_rbe_ff;
  reg          bus_valid_ff, bus_write_ff, bus_last_ff, rvalid_ff;
  reg  [31:0]  bus_addr_ff, bus_wdata_ff, rdata_ff;
  reg  [3:0]   bus_be_ff;
  reg  [1:0]   nxt_widx;
  reg  [3:0]   nxt_part;
  reg  [15:0]  nxt_clear;
  integer      i, j;
  wire         sel_full, sel_aligned, same_blk, overlap, flush_need;
  wire [27:0]  pend_blk;
  wire [1:0]   pend_widx;
  wire         fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  wire [`CWB_ENTRY_W-1:0] fifo_in_data, fifo_out_data;
  wire         xfr_busy, handover, pend_done, unc_load;

  // ==========================================================
  // Static mode straps, resynchronised
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_s1_ff <= 2'h0;
      mode_s2_ff <= 2'h0;
    end
    else
    begin
      mode_s1_ff <= {merge_full_mode, aligned_enable_mode};
      mode_s2_ff <= mode_s1_ff;
    end
  end
  assign sel_full    = mode_s2_ff[1];
  assign sel_aligned = mode_s2_ff[0];
  // ==========================================================
  // Handover decision
  assign pend_blk  = pend_addr_ff[31:`CWB_BLK_LSB];
  assign pend_widx = pend_addr_ff[`CWB_WIDX_MSB:`CWB_WIDX_LSB];
  assign same_blk  = acc_valid_ff && (acc_blk_ff == pend_blk);
  // Any lane already held in the target word counts, not only the same lanes
  assign overlap   = word_be(acc_be_ff, pend_widx) != `CWB_BE_NONE;
  assign flush_need = acc_valid_ff && (pend_barrier_ff || pend_unc_ff ||
                      (!pend_write_ff && same_blk) || (pend_write_ff && !same_blk) ||
                      (pend_write_ff && same_blk && !sel_full && overlap));
  // Draining half counts as busy until its last word has left the bus
  assign xfr_busy = (xfr_be_ff != `CWB_BLK_EMPTY) || xfr_read_ff || fifo_out_valid || bus_valid_ff;
  assign handover = !xfr_busy && acc_valid_ff &&
                    ((pend_valid_ff && flush_need) || (!pend_valid_ff && acc_be_ff == `CWB_BLK_FULL));
  assign unc_load  = pend_unc_ff && !pend_write_ff;
  assign pend_done = pend_valid_ff && !flush_need && !(pend_unc_ff && !pend_barrier_ff && xfr_busy);

  // ==========================================================
  // Core request intake; ready drops while a request is held
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_ff        <= 1'b1;
      pend_valid_ff   <= 1'b0;
      pend_write_ff   <= 1'b0;
      pend_unc_ff     <= 1'b0;
      pend_barrier_ff <= 1'b0;
      pend_addr_ff    <= 32'h0000_0000;
      pend_be_ff      <= 4'h0;
      pend_data_ff    <= 32'h0000_0000;
    end
    else if (core_req_valid && ready_ff)
    begin
      ready_ff        <= 1'b0;
      pend_valid_ff   <= 1'b1;
      pend_write_ff   <= core_req_write;
      pend_unc_ff     <= core_req_uncached;
      pend_barrier_ff <= core_req_barrier;
      pend_addr_ff    <= core_req_addr;
      pend_be_ff      <= core_req_be;
      pend_data_ff    <= core_req_wdata;
    end
    else if (pend_done)
    begin
      ready_ff      <= 1'b1;
      pend_valid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Accumulating half
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_valid_ff <= 1'b0;
      acc_blk_ff   <= 28'h000_0000;
      acc_data_ff  <= 128'h0;
      acc_be_ff    <= `CWB_BLK_EMPTY;
    end
    else if (handover)
    begin
      acc_valid_ff <= 1'b0;
      acc_be_ff    <= `CWB_BLK_EMPTY;
    end
    else if (pend_done && pend_write_ff && !pend_unc_ff && !pend_barrier_ff)
    begin
      // Cached stores merge per byte lane
      acc_valid_ff <= 1'b1;
      acc_blk_ff   <= pend_blk;
      for (i = 0; i < `CWB_BLK_BYTES; i = i + 1)
      begin
        if ((i / `CWB_WORD_LANES) == pend_widx && pend_be_ff[i % `CWB_WORD_LANES])
        begin
          acc_data_ff[i*8 +: 8] <= pend_data_ff[(i % `CWB_WORD_LANES)*8 +: 8];
          acc_be_ff[i]          <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Draining half: walk words low to high, one piece per push
  always @*
  begin
    nxt_widx  = 2'h3;
    nxt_part  = `CWB_BE_NONE;
    nxt_clear = `CWB_BLK_EMPTY;
    for (j = 3; j >= 0; j = j - 1)
    begin
      if (word_be(xfr_be_ff, j[1:0]) != `CWB_BE_NONE)
        nxt_widx = j[1:0];
    end
    nxt_part = first_part(word_be(xfr_be_ff, nxt_widx), sel_aligned);
    nxt_clear[nxt_widx*`CWB_WORD_LANES +: `CWB_WORD_LANES] = nxt_part;
  end

  assign fifo_in_valid = (xfr_be_ff != `CWB_BLK_EMPTY) || xfr_read_ff;
  assign fifo_in_data  = xfr_read_ff ?
                         {1'b0, 1'b1, xfr_blk_ff, xfr_ridx_ff, xfr_rbe_ff, 32'h0000_0000} :
                         {1'b1, ((xfr_be_ff & ~nxt_clear) == `CWB_BLK_EMPTY), xfr_blk_ff, nxt_widx,
                          nxt_part, xfr_data_ff[nxt_widx*32 +: 32]};
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xfr_blk_ff  <= 28'h000_0000;
      xfr_data_ff <= 128'h0;
      xfr_be_ff   <= `CWB_BLK_EMPTY;
      xfr_read_ff <= 1'b0;
      xfr_ridx_ff <= 2'h0;
      xfr_rbe_ff  <= `CWB_BE_NONE;
    end
    else if (handover)
    begin
      xfr_blk_ff  <= acc_blk_ff;
      xfr_data_ff <= acc_data_ff;
      xfr_be_ff   <= acc_be_ff;
    end
    else if (pend_done && pend_unc_ff && !pend_barrier_ff)
    begin
      // Uncached access owns the empty draining half alone
      xfr_blk_ff <= pend_blk;
      if (unc_load)
      begin
        xfr_read_ff <= 1'b1;
        xfr_ridx_ff <= pend_widx;
        xfr_rbe_ff  <= (sel_aligned && !is_simple(pend_be_ff)) ? `CWB_BE_WORD : pend_be_ff;
      end
      else
      begin
        xfr_data_ff[pend_widx*32 +: 32]                                 <= pend_data_ff;
        xfr_be_ff[pend_widx*`CWB_WORD_LANES +: `CWB_WORD_LANES] <= pend_be_ff;
      end
    end
    else if (fifo_in_ready)
    begin
      if (xfr_read_ff)
        xfr_read_ff <= 1'b0;
      else
        xfr_be_ff <= xfr_be_ff & ~nxt_clear;
    end
  end

  // ==========================================================
  // Issue queue between the draining half and the bus
  cwb_fifo #(
    .WIDTH (`CWB_ENTRY_W),
    .DEPTH (`CWB_FIFO_DEPTH),
    .AW    (`CWB_FIFO_AW)
  ) i_cwb_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );
  assign fifo_out_ready = !bus_valid_ff || bus_ready;
  // ==========================================================
  // Bus output stage; holds every field until the agent accepts
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_valid_ff <= 1'b0;
      bus_write_ff <= 1'b0;
      bus_last_ff  <= 1'b0;
      bus_addr_ff  <= 32'h0000_0000;
      bus_be_ff    <= `CWB_BE_NONE;
      bus_wdata_ff <= 32'h0000_0000;
    end
    else if (fifo_out_ready)
    begin
      bus_valid_ff <= fifo_out_valid;
      if (fifo_out_valid)
      begin
        bus_write_ff <= fifo_out_data[`CWB_ENT_WR];
        bus_last_ff  <= fifo_out_data[`CWB_ENT_LAST];
        bus_addr_ff  <= {fifo_out_data[`CWB_ENT_ADDR_MSB:`CWB_ENT_ADDR_LSB], 2'h0};
        bus_be_ff    <= fifo_out_data[`CWB_ENT_BE_MSB:`CWB_ENT_BE_LSB];
        bus_wdata_ff <= fifo_out_data[`CWB_ENT_DATA_MSB:`CWB_ENT_DATA_LSB];
      end
    end
  end

  // ==========================================================
  // Read return
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      rvalid_ff <= bus_rvalid;
      if (bus_rvalid)
        rdata_ff <= bus_rdata;
    end
  end

  assign core_req_ready        = ready_ff;
  assign core_rvalid           = rvalid_ff;
  assign core_rdata            = rdata_ff;
  assign bus_valid             = bus_valid_ff;
  assign bus_write             = bus_write_ff;
  assign bus_last              = bus_last_ff;
  assign bus_addr              = bus_addr_ff;
  assign bus_byte_lane_enables = bus_be_ff;
  assign bus_wdata             = bus_wdata_ff;
endmodule

// ### testbench/cwb_bus_agent.sv
// Bus agent model facing cwb_biu: accepts beats, returns read data.
// Assumes the same clock as the design; slow adds random stalls, hold stops all.
module cwb_bus_agent (
  input  wire         clock,
  input  wire         arst_n,
  input  wire         slow,
  input  wire         hold,
  input  wire         bus_valid,
  input  wire         bus_write,
  input  wire  [31:0] bus_addr,
  output logic        bus_ready,
  output logic        bus_rvalid,
  output logic [31:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  integer      seed_ag = 4242;
  logic [31:0] pat_ff;
  // ==========================================================
  // Accept and answer
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_ready  <= 1'h0;
      bus_rvalid <= 1'h0;
      bus_rdata  <= 32'h0;
      pat_ff     <= 32'h0;
    end
    else
    begin
      pat_ff     <= pat_ff + 32'h9E37_79B9;
      bus_ready  <= !hold && (!slow || ($random(seed_ag) % 3 != 0));
      bus_rvalid <= bus_valid && bus_ready && !bus_write;
      // Data line changes every cycle outside a return, so stale data never matches
      bus_rdata  <= (bus_valid && bus_ready && !bus_write) ? ~bus_addr : pat_ff;
    end
  end
endmodule

// ### testbench/cwb_biu_sva.sv
// Checker for cwb_biu bus and core handshakes, bound to the top module.
// Assumes mode straps only change while reset is held.
module cwb_biu_sva (
  input wire        clock,
  input wire        arst_n,
  input wire        aligned_enable_mode,
  input wire        core_req_valid,
  input wire        core_req_ready,
  input wire        core_rvalid,
  input wire [31:0] core_rdata,
  input wire        bus_valid,
  input wire        bus_ready,
  input wire        bus_write,
  input wire        bus_last,
  input wire [31:0] bus_addr,
  input wire [3:0]  bus_byte_lane_enables,
  input wire [31:0] bus_wdata,
  input wire        bus_rvalid,
  input wire [31:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic        burst_ff;
  logic [27:0] blk_ff;
  logic [1:0]  widx_ff;
  // ==========================================================
  // Burst tracking: beats of one block stay in it and never step back
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      burst_ff <= 1'h0;
    else if (bus_valid && bus_ready)
      burst_ff <= bus_write && !bus_last;
  end
  always @(posedge clock)
  begin
    if (bus_valid && bus_ready)
    begin
      blk_ff  <= bus_addr[31:4];
      widx_ff <= bus_addr[3:2];
    end
  end
  // ==========================================================
  // Properties
  property p_hold;
    bus_valid && !bus_ready |=> bus_valid && $stable({bus_write, bus_last, bus_addr, bus_byte_lane_enables, bus_wdata});
  endproperty
  a_hold: assert property (p_hold) else $error("bus beat changed before acceptance");
  property p_word_addr;
    bus_valid |-> bus_addr[1:0] == 2'h0;
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("bus address not word aligned");
  property p_lanes;
    bus_valid |-> bus_byte_lane_enables != 4'h0;
  endproperty
  a_lanes: assert property (p_lanes) else $error("bus beat without lanes");
  property p_simple;
    aligned_enable_mode && bus_valid |-> bus_byte_lane_enables inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  endproperty
  a_simple: assert property (p_simple) else $error("irregular lanes in aligned mode");
  property p_read_alone;
    bus_valid && !bus_write |-> bus_last;
  endproperty
  a_read_alone: assert property (p_read_alone) else $error("read not a single access");
  property p_rdata;
    bus_rvalid |=> core_rvalid && core_rdata == $past(bus_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data not returned next cycle");
  property p_rv_src;
    core_rvalid |-> $past(bus_rvalid);
  endproperty
  a_rv_src: assert property (p_rv_src) else $error("read return without bus data");
  property p_stall;
    core_req_valid && core_req_ready |=> !core_req_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("ready stayed high after a request");
  property p_block;
    bus_valid && burst_ff |-> bus_addr[31:4] == blk_ff && bus_addr[3:2] >= widx_ff;
  endproperty
  a_block: assert property (p_block) else $error("burst left its block or stepped back");
  c_last: cover property (bus_valid && bus_ready && bus_write && bus_last);
  c_read: cover property (core_rvalid);
  c_split: cover property (aligned_enable_mode && bus_valid && bus_byte_lane_enables == 4'hC);
endmodule
bind cwb_biu cwb_biu_sva i_cwb_biu_sva (.clock(clock), .arst_n(arst_n), .aligned_enable_mode(aligned_enable_mode),
  .core_req_valid(core_req_valid), .core_req_ready(core_req_ready), .core_rvalid(core_rvalid),
  .core_rdata(core_rdata), .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_write(bus_write),
  .bus_last(bus_last), .bus_addr(bus_addr), .bus_byte_lane_enables(bus_byte_lane_enables),
  .bus_wdata(bus_wdata), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata));

// ### testbench/collapsing_write_buffer_biu_tb.sv
// Self-checking bench for cwb_biu: core requests in, bus beats checked in order.
// Assumes cwb_bus_agent on the bus side and the bound checker.
module collapsing_write_buffer_biu_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'h0, arst_n = 1'h0, merge_full_mode = 1'h1, aligned_enable_mode = 1'h0;
  logic        slow = 1'h0, hold = 1'h0, core_req_valid = 1'h0, core_req_write = 1'h0;
  logic        core_req_uncached = 1'h0, core_req_barrier = 1'h0;
  logic [31:0] core_req_addr = 32'h0, core_req_wdata = 32'h0, a, d, rd_addr;
  logic [3:0]  core_req_be = 4'h0, be;
  wire         core_req_ready, core_rvalid, bus_valid, bus_ready, bus_write, bus_last, bus_rvalid;
  wire  [31:0] core_rdata, bus_addr, bus_wdata, bus_rdata;
  wire  [3:0]  bus_byte_lane_enables;
  logic [69:0] exq[$];
  logic [69:0] w_mon;
  integer      seed, n_mismatch = 0, n_checks = 0, n_rd = 0, i;
  always #10 clock = ~clock;
  cwb_biu i_cwb_biu (.clock(clock), .arst_n(arst_n), .merge_full_mode(merge_full_mode),
    .aligned_enable_mode(aligned_enable_mode), .core_req_valid(core_req_valid), .core_req_ready(core_req_ready),
    .core_req_write(core_req_write), .core_req_uncached(core_req_uncached), .core_req_barrier(core_req_barrier),
    .core_req_addr(core_req_addr), .core_req_be(core_req_be), .core_req_wdata(core_req_wdata),
    .core_rvalid(core_rvalid), .core_rdata(core_rdata), .bus_valid(bus_valid), .bus_ready(bus_ready),
    .bus_write(bus_write), .bus_last(bus_last), .bus_addr(bus_addr), .bus_byte_lane_enables(bus_byte_lane_enables),
    .bus_wdata(bus_wdata), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata));
  cwb_bus_agent i_cwb_bus_agent (.clock(clock), .arst_n(arst_n), .slow(slow), .hold(hold), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_ready(bus_ready), .bus_rvalid(bus_rvalid),
    .bus_rdata(bus_rdata));
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] lmask(input logic [3:0] m);
    lmask = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction
  function automatic logic simple(input logic [3:0] m);
    simple = m inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  endfunction
  function automatic logic [3:0] piece(input logic [3:0] m);
    piece = (m[1:0] == 2'h3) ? 4'h3 : (m[3:2] == 2'h3) ? 4'hC : (m & (~m + 4'h1));
  endfunction
  // Irregular lanes in aligned mode give a full halfword first where one is set, then single bytes
  task automatic expw(input logic [31:0] ad, input logic [3:0] m, input logic [31:0] dt, input logic l);
    logic [3:0] rem, p;
    rem = m;
    while (rem != 4'h0)
    begin
      p = (aligned_enable_mode && !simple(rem)) ? piece(rem) : rem;
      rem = rem & ~p;
      exq.push_back({1'h1, l && (rem == 4'h0), ad, p, dt & lmask(p)});
    end
  endtask
  task automatic chk_beat(input logic [69:0] got, input logic [69:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // ==========================================================
  // Drivers and monitors
  task automatic req(input logic wr, un, br, input logic [31:0] ad, input logic [3:0] m, input logic [31:0] dt);
    int t;
    @(posedge clock);
    #1;
    {core_req_valid, core_req_write, core_req_uncached, core_req_barrier} = {1'h1, wr, un, br};
    {core_req_addr, core_req_be, core_req_wdata} = {ad, m, dt};
    t = 0;
    while (core_req_ready !== 1'h1 && t < 3000)
    begin
      @(posedge clock);
      #1;
      t++;
    end
    if (t >= 3000)
      n_mismatch++;
    @(posedge clock);
    #1;
    core_req_valid = 1'h0;
  endtask
  task automatic drain(input string name);
    int t;
    t = 0;
    while ((exq.size() != 0 || bus_valid !== 1'h0) && t < 3000)
    begin
      @(posedge clock);
      t++;
    end
    if (t >= 3000)
      n_mismatch++;
    // A last read return reaches the core two cycles after the bus took it
    repeat (4) @(posedge clock);
    #1;
    chk_val(32'(exq.size()), 32'h0);
    $display("test %s done, checks %0d", name, n_checks);
  endtask
  always @(posedge clock)
  begin
    if (bus_valid && bus_ready)
    begin
      w_mon = (exq.size() != 0) ? exq.pop_front() : {70{1'h1}};
      chk_beat({bus_write, bus_last, bus_addr, bus_byte_lane_enables, bus_wdata & lmask(w_mon[35:32])}, w_mon);
    end
    if (core_rvalid)
    begin
      chk_val(core_rdata, ~rd_addr);
      n_rd++;
    end
  end
  // Mode straps change only while reset is held
  task automatic do_reset(input logic mf, input logic al);
    arst_n = 1'h0;
    merge_full_mode = mf;
    aligned_enable_mode = al;
    repeat (16) @(posedge clock);
    #1;
    arst_n = 1'h1;
  endtask
  // Cached store puts one word in the held block, handed over by the first uncached store; then every lane pattern uncached
  task automatic unc_loop(input string name);
    a = $random(seed) & 32'hFFFF_FFF0;
    d = $random(seed);
    rd_addr = a;
    expw(a + 32'h84, 4'hF, d, 1'h1);
    req(1'h1, 1'h0, 1'h0, a + 32'h84, 4'hF, d);
    for (i = 1; i < 16; i++)
    begin
      be = i[3:0];
      d = $random(seed);
      expw(a, be, d, 1'h1);
      req(1'h1, 1'h1, 1'h0, a, be, d);
      exq.push_back({2'h1, a, (aligned_enable_mode && !simple(be)) ? 4'hF : be, 32'h0});
      req(1'h0, 1'h1, 1'h0, a, be, 32'h0);
    end
    drain(name);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 29199;
    do_reset(1'h1, 1'h0);
    a = $random(seed) & 32'hFFFF_FFF0;
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed);
      expw(a + 4 * i, 4'hF, d, i == 3);
      req(1'h1, 1'h0, 1'h0, a + 4 * i, 4'hF, d);
    end
    drain("full_block");
    d = $random(seed);
    expw(a + 32'h4, 4'h5, d, 1'h0);
    expw(a + 32'hC, 4'hC, d, 1'h1);
    expw(a + 32'h20, 4'hF, d, 1'h1);
    expw(a + 32'h40, 4'h3, d, 1'h1);
    req(1'h1, 1'h0, 1'h0, a + 32'h4, 4'h1, d);
    req(1'h1, 1'h0, 1'h0, a + 32'h4, 4'h4, d);
    req(1'h1, 1'h0, 1'h0, a + 32'hC, 4'hC, d);
    req(1'h1, 1'h0, 1'h0, a + 32'h20, 4'hF, d);
    req(1'h0, 1'h0, 1'h1, 32'h0, 4'h0, 32'h0);
    req(1'h1, 1'h0, 1'h0, a + 32'h40, 4'h3, d);
    req(1'h0, 1'h0, 1'h0, a + 32'h40, 4'hF, 32'h0);
    drain("merge_flush");
    unc_loop("uncached_plain");
    do_reset(1'h0, 1'h1);
    slow = 1'h1;
    d = $random(seed);
    expw(a, 4'h1, d, 1'h1);
    expw(a, 4'h2, d, 1'h0);
    expw(a + 32'h8, 4'hF, d, 1'h1);
    req(1'h1, 1'h0, 1'h0, a, 4'h1, d);
    req(1'h1, 1'h0, 1'h0, a, 4'h2, d);
    req(1'h1, 1'h0, 1'h0, a + 32'h8, 4'hF, d);
    req(1'h0, 1'h0, 1'h1, 32'h0, 4'h0, 32'h0);
    drain("no_merge");
    unc_loop("uncached_aligned");
    // Bus held off: one block waits in the queue, core must stall until the bus drains
    hold = 1'h1;
    fork
      for (int k = 0; k < 36; k++)
      begin
        d = $random(seed);
        expw(a + 4 * k, 4'hF, d, k % 4 == 3);
        req(1'h1, 1'h0, 1'h0, a + 4 * k, 4'hF, d);
      end
      begin
        repeat (300) @(posedge clock);
        #1;
        hold = 1'h0;
      end
    join
    drain("fill_stall");
    chk_val(32'(n_rd), 32'd30);
    results();
  end
  // Tests need under a thousand cycles; this is 75000 cycles, over seventy times that
  initial
  begin
    #1_500_000;
    n_mismatch++;
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
endmodule
